// ===== hdl/config_load_device.sv
// Device end of the parallel configuration load port
// Operation
// - Wait fast or standard power-on delay first
// - Host load clock is ratio times word rate
// - Byte mode ratio: one, two with compression
// - Word mode ratio: one, two encrypted, four compressed
// - Host gives ratio minus one trailing edges
// - Request low drops done and status quickly
// - Host holds request low two microseconds
// - Status low 268 to 1506 microseconds
// - Status released within 1506 us of request
// - Host waits after status before first edge
// - Word captured on rising load clock edge
// - Host load clock limited to 125 MHz
// - Oscillator init: user mode 175-437 us later
// - User init clock enabled after four periods
// - Initialization needs 17408 init clock cycles
// - Host holds word ratio minus one periods
`timescale 1ns/10ps
`default_nettype none
module config_load_device #(
  parameter int unsigned POR_FAST_CYC = config_load_pkg::POR_FAST_DEF,
  parameter int unsigned POR_STD_CYC = config_load_pkg::POR_STD_DEF,
  parameter int unsigned INIT_CYCLES = config_load_pkg::INIT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  config_load_if.device link,
  input wire logic [config_load_pkg::SEL_W-1:0] scheme_select,
  input wire logic [config_load_pkg::WORDS_W-1:0] stream_words,
  input wire logic user_init_clock,
  output logic [config_load_pkg::DATA_W-1:0] cfg_word,
  output logic cfg_valid,
  output logic user_mode,
  output logic init_clock_enable,
  output logic loading
);
  import config_load_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    core_state_t state;
    logic [TMR_W-1:0] timer;
    logic [SEL_W-1:0] sel;
    logic sel_taken;
    logic req_s1;
    logic req_s2;
    logic cmp_s1;
    logic cmp_s2;
    logic stat_s1;
    logic stat_s2;
    logic uck_s1;
    logic uck_s2;
    logic uck_s3;
    logic done;
    logic status_oe;
    logic user_mode;
    logic init_en;
    logic link_run;
  } core_t;

  typedef struct packed {
    logic [EDGE_W-1:0] edge_idx;
    logic [WORDS_W-1:0] count;
    logic [DATA_W-1:0] word;
    logic valid;
    logic complete;
  } link_t;

  localparam core_t CORE_RST = '{state: C_POR, status_oe: 1'b1, req_s1: 1'b1, req_s2: 1'b1, default: '0};
  localparam link_t LINK_RST = '0;
  localparam logic [TMR_W-1:0] POR_FAST_T = TMR_W'(POR_FAST_CYC - 1);
  localparam logic [TMR_W-1:0] POR_STD_T = TMR_W'(POR_STD_CYC - 1);
  localparam logic [TMR_W-1:0] STATUS_T = TMR_W'(STATUS_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] CD2UM_T = TMR_W'(CD2UM_CYC - 1);
  localparam logic [TMR_W-1:0] CD2CU_T = TMR_W'(CD2CU_CYC - 1);
  localparam logic [TMR_W-1:0] INIT_T = TMR_W'(INIT_CYCLES - 1);

  core_t c;
  core_t next_c;
  link_t l;
  link_t next_l;
  logic [TMR_W-1:0] por_t;
  logic uck_rise;

  ////////////////////////////////////////////////////////////////////////
  // Core on clk
  assign por_t = c.sel[SEL_PORFAST] ? POR_FAST_T : POR_STD_T;
  assign uck_rise = c.uck_s2 && !c.uck_s3;

  always_comb begin
    next_c = c;
    next_c.req_s1 = link.config_request_n;
    next_c.req_s2 = c.req_s1;
    next_c.cmp_s1 = l.complete;
    next_c.cmp_s2 = c.cmp_s1;
    next_c.stat_s1 = link.status_ready;
    next_c.stat_s2 = c.stat_s1;
    next_c.uck_s1 = user_init_clock;
    next_c.uck_s2 = c.uck_s1;
    next_c.uck_s3 = c.uck_s2;
    case (c.state)
      C_POR: begin
        next_c.timer = c.timer + 1'b1;
        if (!c.sel_taken) begin
          next_c.sel = scheme_select;
          next_c.sel_taken = 1'b1;
        end else if (c.timer >= por_t) begin
          next_c.state = C_HOLD;
          next_c.timer = '0;
        end
      end
      C_HOLD: begin
        if (!c.req_s2) begin
          next_c.timer = '0;
        end else if (c.timer == STATUS_T) begin
          next_c.state = C_LOAD;
          next_c.status_oe = 1'b0;
          next_c.timer = '0;
        end else begin
          next_c.timer = c.timer + 1'b1;
        end
      end
      C_LOAD: begin
        next_c.link_run = c.stat_s2;
        if (c.cmp_s2) begin
          next_c.done = 1'b1;
          next_c.link_run = 1'b0;
          next_c.state = C_INIT;
          next_c.timer = '0;
        end
      end
      C_INIT: begin
        if (!c.sel[SEL_USRCLK]) begin
          next_c.timer = c.timer + 1'b1;
          if (c.timer == CD2UM_T) begin
            next_c.state = C_USER;
            next_c.user_mode = 1'b1;
          end
        end else if (!c.init_en) begin
          next_c.timer = c.timer + 1'b1;
          if (c.timer == CD2CU_T) begin
            next_c.init_en = 1'b1;
            next_c.timer = '0;
          end
        end else if (uck_rise) begin
          next_c.timer = c.timer + 1'b1;
          if (c.timer == INIT_T) begin
            next_c.state = C_USER;
            next_c.user_mode = 1'b1;
          end
        end
      end
      C_USER: begin
        next_c.user_mode = 1'b1;
      end
      default: begin
        next_c = CORE_RST;
      end
    endcase
    if (!c.req_s2 && c.state != C_POR) begin
      next_c.state = C_HOLD;
      next_c.timer = '0;
      next_c.done = 1'b0;
      next_c.status_oe = 1'b1;
      next_c.user_mode = 1'b0;
      next_c.init_en = 1'b0;
      next_c.link_run = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      c <= CORE_RST;
    end else if (ce) begin
      c <= next_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture on the load clock; cleared while the core is not loading
  always_comb begin
    next_l = l;
    next_l.valid = 1'b0;
    if (l.edge_idx == '0 && l.count != stream_words) begin
      next_l.word = c.sel[SEL_WIDE] ? link.data : {BYTE_W'(0), link.data[BYTE_W-1:0]};
      next_l.valid = 1'b1;
      next_l.count = l.count + 1'b1;
    end
    if (l.edge_idx == last_edge(c.sel)) begin
      next_l.edge_idx = '0;
    end else begin
      next_l.edge_idx = l.edge_idx + 1'b1;
    end
    next_l.complete = l.complete || (next_l.count == stream_words && next_l.edge_idx == '0);
  end

  always_ff @(posedge link.load_clock or negedge c.link_run) begin
    if (!c.link_run) begin
      l <= LINK_RST;
    end else begin
      l <= next_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.dev_status_out = 1'b0;
  assign link.dev_status_oe = c.status_oe;
  assign link.config_done = c.done;
  assign cfg_word = l.word;
  assign cfg_valid = l.valid;
  assign user_mode = c.user_mode;
  assign init_clock_enable = c.init_en;
  assign loading = c.link_run;
endmodule
`default_nettype wire

// ===== hdl/config_load_pkg.sv
// Shared constants, types and decoders of the parallel configuration load port
package config_load_pkg;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORDS_W = 24;
  localparam int TMR_W = 20;
  localparam int EDGE_W = 2;
  localparam int RATIO_W = 3;
  localparam int FIFO_DEPTH = 32;
  // Field positions of scheme_select
  localparam int SEL_W = 5;
  localparam int SEL_WIDE = 0;
  localparam int SEL_ENC = 1;
  localparam int SEL_CMP = 2;
  localparam int SEL_USRCLK = 3;
  localparam int SEL_PORFAST = 4;
  // Times in their own units and the derived clk counts
  localparam int unsigned POR_FAST_MS = 4;
  localparam int unsigned POR_STD_MS = 100;
  localparam int unsigned POR_FAST_DEF = POR_FAST_MS * CLK_KHZ;
  localparam int unsigned POR_STD_DEF = POR_STD_MS * CLK_KHZ;
  localparam int unsigned STATUS_LOW_US = 268;
  localparam int unsigned STATUS_LOW_CYC = STATUS_LOW_US * CLK_MHZ;
  localparam int unsigned REQ_LOW_US = 2;
  localparam int unsigned REQ_LOW_CYC = REQ_LOW_US * CLK_MHZ;
  localparam int unsigned ST2CK_US = 2;
  localparam int unsigned ST2CK_CYC = ST2CK_US * CLK_MHZ;
  localparam int unsigned CD2UM_MIN_US = 175;
  localparam int unsigned CD2UM_CYC = CD2UM_MIN_US * CLK_MHZ;
  localparam int unsigned LOAD_CLK_MAX_MHZ = 125;
  localparam int unsigned CD2CU_PERIODS = 4;
  localparam int unsigned CD2CU_NS = CD2CU_PERIODS * 1000 / LOAD_CLK_MAX_MHZ;
  localparam int unsigned CD2CU_RAW = (CD2CU_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CD2CU_CYC = (CD2CU_RAW > 0) ? CD2CU_RAW : 1;
  localparam int unsigned INIT_CYCLES_DEF = 17408;
  // Load ratio encodings
  localparam logic [RATIO_W-1:0] RATIO_X1 = 3'h1;
  localparam logic [RATIO_W-1:0] RATIO_X2 = 3'h2;
  localparam logic [RATIO_W-1:0] RATIO_X4 = 3'h4;

  typedef enum logic [2:0] {
    C_POR = 3'h0, C_HOLD = 3'h1, C_LOAD = 3'h3, C_INIT = 3'h2, C_USER = 3'h6
  } core_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_REQ = 3'h1, H_WSTAT = 3'h3, H_GAP = 3'h2, H_STREAM = 3'h6,
    H_WDONE = 3'h7
  } host_state_t;

  // Load clock edges per word for a scheme
  function automatic logic [RATIO_W-1:0] load_ratio(input logic [SEL_W-1:0] s);
    if (s[SEL_CMP]) begin
      return s[SEL_WIDE] ? RATIO_X4 : RATIO_X2;
    end
    return (s[SEL_WIDE] && s[SEL_ENC]) ? RATIO_X2 : RATIO_X1;
  endfunction

  // Index of the last edge of a word period
  function automatic logic [EDGE_W-1:0] last_edge(input logic [SEL_W-1:0] s);
    logic [RATIO_W-1:0] r;
    r = load_ratio(s) - RATIO_X1;
    return r[EDGE_W-1:0];
  endfunction
endpackage

// ===== hdl/config_load_if.sv
// Pins between the configuration host and the loaded device
`timescale 1ns/10ps
`default_nettype none
interface config_load_if;
  import config_load_pkg::*;
  logic config_request_n;
  logic load_clock;
  logic [DATA_W-1:0] data;
  logic dev_status_out;
  logic dev_status_oe;
  logic ext_status_hold;
  logic status_ready;
  logic config_done;

  // Open-drain status with pull-up; an outside party may hold it low
  assign status_ready = !(dev_status_oe && !dev_status_out) && !ext_status_hold;

  modport device(
    input config_request_n,
    input load_clock,
    input data,
    input status_ready,
    output dev_status_out,
    output dev_status_oe,
    output config_done
  );

  modport host(
    output config_request_n,
    output load_clock,
    output data,
    input status_ready,
    input config_done
  );
endinterface
`default_nettype wire

// ===== hdl/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic ready;
    logic valid;
  } fifo_t;
  fifo_t s;
  fifo_t next_s;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = s.ready;
  assign out_valid = s.valid;
  assign out_data = mem[s.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wptr = s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = s.rptr + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    next_s.ready = next_s.count != (AW+1)'(DEPTH);
    next_s.valid = next_s.count != '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '{ready: 1'b1, default: '0};
    end else if (ce) begin
      s <= next_s;
      if (push) begin
        mem[s.wptr] <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/config_load_host.sv
// Host end of the parallel configuration load port
`timescale 1ns/10ps
`default_nettype none
module config_load_host (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  config_load_if.host link,
  input wire logic start,
  input wire logic [config_load_pkg::SEL_W-1:0] scheme_select,
  input wire logic [config_load_pkg::WORDS_W-1:0] stream_words,
  input wire logic [config_load_pkg::DATA_W-1:0] word_data,
  input wire logic word_valid,
  output logic word_ready,
  output logic busy,
  output logic finished
);
  import config_load_pkg::*;

  typedef struct packed {
    host_state_t state;
    logic [TMR_W-1:0] timer;
    logic [SEL_W-1:0] sel;
    logic [WORDS_W-1:0] total;
    logic [WORDS_W-1:0] sent;
    logic [EDGE_W-1:0] edge_idx;
    logic load_clk;
    logic lclk_out;
    logic [DATA_W-1:0] data;
    logic req_n;
    logic stat_s1;
    logic stat_s2;
    logic done_s1;
    logic done_s2;
    logic busy;
    logic finished;
  } host_t;

  localparam host_t HOST_RST = '{state: H_IDLE, req_n: 1'b1, default: '0};
  localparam logic [TMR_W-1:0] REQ_T = TMR_W'(REQ_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_T = TMR_W'(ST2CK_CYC - 1);

  host_t c;
  host_t next_c;
  logic [DATA_W-1:0] f_data;
  logic f_valid;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Word buffer
  sync_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .in_data(word_data),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(pop)
  );

  assign pop = c.state == H_STREAM && !c.load_clk && c.edge_idx == '0 && c.sent != c.total && f_valid;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer; load clock is clk divided by two
  always_comb begin
    next_c = c;
    next_c.stat_s1 = link.status_ready;
    next_c.stat_s2 = c.stat_s1;
    next_c.done_s1 = link.config_done;
    next_c.done_s2 = c.done_s1;
    // Pin clock lags the word by one clk so data is set up before the rise
    next_c.lclk_out = c.load_clk;
    case (c.state)
      H_IDLE: begin
        if (start) begin
          next_c.state = H_REQ;
          next_c.sel = scheme_select;
          next_c.total = stream_words;
          next_c.sent = '0;
          next_c.edge_idx = '0;
          next_c.timer = '0;
          next_c.req_n = 1'b0;
          next_c.busy = 1'b1;
          next_c.finished = 1'b0;
        end
      end
      H_REQ: begin
        next_c.timer = c.timer + 1'b1;
        if (c.timer >= REQ_T && !c.stat_s2) begin
          next_c.req_n = 1'b1;
          next_c.state = H_WSTAT;
        end
      end
      H_WSTAT: begin
        next_c.timer = '0;
        if (c.stat_s2) begin
          next_c.state = H_GAP;
        end
      end
      H_GAP: begin
        next_c.timer = c.timer + 1'b1;
        if (c.timer == GAP_T) begin
          next_c.state = H_STREAM;
        end
      end
      H_STREAM: begin
        if (c.load_clk) begin
          next_c.load_clk = 1'b0;
        end else if (c.edge_idx != '0 || pop) begin
          next_c.load_clk = 1'b1;
          next_c.edge_idx = (c.edge_idx == last_edge(c.sel)) ? '0 : c.edge_idx + 1'b1;
          if (pop) begin
            next_c.data = f_data;
            next_c.sent = c.sent + 1'b1;
          end
        end else if (c.sent == c.total) begin
          next_c.state = H_WDONE;
        end
      end
      H_WDONE: begin
        if (c.done_s2) begin
          next_c.state = H_IDLE;
          next_c.busy = 1'b0;
          next_c.finished = 1'b1;
        end
      end
      default: begin
        next_c = HOST_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      c <= HOST_RST;
    end else if (ce) begin
      c <= next_c;
    end
  end

  assign link.config_request_n = c.req_n;
  assign link.load_clock = c.lclk_out;
  assign link.data = c.data;
  assign busy = c.busy;
  assign finished = c.finished;
endmodule
`default_nettype wire

// ===== testbench/config_load_sva.sv
// Concurrent checks on the configuration link pins
`timescale 1ns/10ps
`default_nettype none
module config_load_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic config_request_n,
  input wire logic load_clock,
  input wire logic [config_load_pkg::DATA_W-1:0] data,
  input wire logic dev_status_oe,
  input wire logic ext_status_hold,
  input wire logic status_ready,
  input wire logic config_done
);
  import config_load_pkg::*;
  typedef struct packed {
    logic lclk_q;
    logic [7:0] req_low;
    logic [15:0] since_req;
    logic [7:0] since_stat;
    logic [7:0] since_edge;
  } sva_state_t;
  sva_state_t st;
  sva_state_t next_st;
  ////////////////////////////////
  // Saturating elapsed-cycle counters
  always_comb begin
    next_st = st;
    next_st.lclk_q = load_clock;
    next_st.req_low = config_request_n ? 8'h00 : st.req_low + {7'h00, ~&st.req_low};
    next_st.since_req = config_request_n ? st.since_req + {15'h0000, ~&st.since_req} : 16'h0000;
    next_st.since_stat = status_ready ? st.since_stat + {7'h00, ~&st.since_stat} : 8'h00;
    next_st.since_edge = (load_clock && !st.lclk_q) ? 8'h00 : st.since_edge + {7'h00, ~&st.since_edge};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= {33'h0, 8'hff};
    end else begin
      st <= next_st;
    end
  end
  ////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_done_status_drop: assert property (
    $fell(config_request_n) |-> ##[1:6] (!config_done && dev_status_oe)) else $error("done or status not dropped");
  chk_request_low_width: assert property (
    $rose(config_request_n) |-> st.req_low >= 8'd20) else $error("request low pulse too short");
  chk_status_min_low: assert property (
    $rose(status_ready) |-> st.since_req >= 16'd2680) else $error("status released too early");
  chk_status_max_low: assert property (
    (st.since_req >= 16'd15060 && !ext_status_hold) |-> status_ready) else $error("status held too long");
  chk_first_edge_gap: assert property (
    $rose(load_clock) |-> st.since_stat >= 8'd20) else $error("load clock too soon after status");
  chk_clock_quiet: assert property (
    !(config_request_n && status_ready) |-> !load_clock) else $error("load clock outside stream");
  chk_clock_high_phase: assert property (
    $rose(load_clock) |=> !load_clock) else $error("load clock high phase wrong");
  chk_data_hold: assert property (
    $rose(load_clock) |-> $stable(data)) else $error("data moved at load clock rise");
  chk_done_after_edges: assert property (
    $rose(config_done) |-> st.since_edge <= 8'd6) else $error("done not tied to last edge");
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import config_load_pkg::*;
  typedef struct {logic [SEL_W-1:0] sel; int n; int r;} row_t;
  row_t rows [8] = '{'{5'h10, 3, 1}, '{5'h02, 4, 1}, '{5'h14, 5, 2}, '{5'h06, 2, 2},
    '{5'h01, 32, 1}, '{5'h13, 3, 2}, '{5'h05, 3, 4}, '{5'h1f, 2, 4}};
  logic clk = 1'b0;
  logic uclk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic word_valid = 1'b0;
  logic [SEL_W-1:0] sel = '0;
  logic [WORDS_W-1:0] nwords = '0;
  logic [DATA_W-1:0] word_data = '0;
  logic [DATA_W-1:0] cfg_word;
  logic cfg_valid, user_mode, init_clock_enable, loading, word_ready, busy, finished;
  logic [DATA_W-1:0] got [$];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lrise = 0;
  int urise = 0;
  config_load_if link();
  config_load_device #(.POR_FAST_CYC(50), .POR_STD_CYC(60), .INIT_CYCLES(40)) config_load_device_i (
    .clk(clk), .srst(srst), .ce(1'b1), .link(link), .scheme_select(sel), .stream_words(nwords),
    .user_init_clock(uclk), .cfg_word(cfg_word), .cfg_valid(cfg_valid), .user_mode(user_mode),
    .init_clock_enable(init_clock_enable), .loading(loading));
  config_load_host config_load_host_i (.clk(clk), .srst(srst), .ce(1'b1), .link(link), .start(start),
    .scheme_select(sel), .stream_words(nwords), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .busy(busy), .finished(finished));
  config_load_sva config_load_sva_i (.clk(clk), .srst(srst), .config_request_n(link.config_request_n),
    .load_clock(link.load_clock), .data(link.data), .dev_status_oe(link.dev_status_oe),
    .ext_status_hold(link.ext_status_hold), .status_ready(link.status_ready), .config_done(link.config_done));
  ////////////////////////////////
  always #50 clk = ~clk;
  always #250 uclk = ~uclk;
  always @(posedge link.load_clock) lrise++;
  always @(posedge uclk) urise++;
  always @(negedge link.load_clock) if (cfg_valid === 1'b1) got.push_back(cfg_word);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////
  task check_val(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, m, g, e);
    end
  endtask
  task check_bit(input logic g, input logic e, input string m);
    check_val({31'h0, g}, {31'h0, e}, m);
  endtask
  function automatic logic [DATA_W-1:0] wval(input int k, input int i);
    logic [DATA_W-1:0] v;
    v = 16'h5a3c ^ 16'(i * 291 + k);
    return rows[k].sel[SEL_WIDE] ? v : {8'h00, v[7:0]};
  endfunction
  task do_reset(input int k);
    srst <= 1'b1;
    sel <= rows[k].sel;
    nwords <= rows[k].n[WORDS_W-1:0];
    repeat (6) @(posedge clk);
    check_bit(link.config_done, 1'b0, "done at reset");
    check_bit(link.status_ready, 1'b0, "status at reset");
    check_bit(link.config_request_n, 1'b1, "request at reset");
    check_bit(user_mode | busy | finished | link.load_clock, 1'b0, "flags at reset");
    srst <= 1'b0;
  endtask
  // Mode 0 plain, 1 status held outside, 2 reload without reset
  task load(input int k, input int mode);
    int t;
    got.delete();
    word_valid <= 1'b1;
    for (int i = 0; i < rows[k].n; i++) begin
      word_data <= wval(k, i);
      do @(posedge clk); while (word_ready !== 1'b1);
    end
    word_valid <= 1'b0;
    @(posedge clk);
    if (rows[k].n == FIFO_DEPTH) check_bit(word_ready, 1'b0, "full fifo ready");
    lrise = 0;
    if (mode == 1) link.ext_status_hold <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    if (mode == 2) begin
      repeat (7) @(posedge clk);
      check_bit(link.config_done | link.status_ready, 1'b0, "done or status kept");
    end
    if (mode == 1) begin
      repeat (3200) @(posedge clk);
      check_bit(link.status_ready, 1'b0, "status not held");
      check_val(lrise, 0, "edges while held");
      check_bit(loading, 1'b0, "link running while held");
      link.ext_status_hold <= 1'b0;
      repeat (3) @(posedge clk);
      check_bit(link.status_ready, 1'b1, "status not released");
    end
    while (link.config_done !== 1'b1) @(posedge clk);
    t = 0;
    urise = 0;
    if (mode != 2) begin
      check_bit(init_clock_enable, 1'b0, "init clock early");
      while (user_mode !== 1'b1) begin
        @(posedge clk);
        t++;
      end
      if (rows[k].sel[SEL_USRCLK]) begin
        check_bit(init_clock_enable, 1'b1, "init clock off");
        check_bit(urise >= 40, 1'b1, "too few init cycles");
      end else begin
        check_bit(t >= 1750 && t <= 4370, 1'b1, "init time");
      end
    end
    repeat (4) @(posedge clk);
    check_bit(finished, 1'b1, "host not finished");
    check_val(lrise, rows[k].n * rows[k].r, "load clock edges");
    check_val(got.size(), rows[k].n, "word count");
    foreach (got[i]) check_val(got[i], wval(k, i), "word");
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    link.ext_status_hold = 1'b0;
    for (int k = 0; k < 8; k++) begin
      do_reset(k);
      load(k, 0);
    end
    // Outside hold on status, then a second load without reset
    do_reset(0);
    load(0, 1);
    load(0, 2);
    repeat (13000) @(posedge clk);
    check_bit(link.status_ready & user_mode, 1'b1, "status or user mode lost");
    end_sim();
  end
endmodule
`default_nettype wire
